/* File: inc/rtc_ctrl_pkg.sv */
// Constants for the clock control and retention status registers
package rtc_ctrl_pkg;
  localparam int         ADDR_W         = 20;
  localparam int         DATA_W         = 8;
  localparam int         SEL_W          = 3;
  localparam logic [19:0] RETN_STAT_OFF = 20'hF00F9;
  localparam logic [19:0] CLK_CTRL0_OFF = 20'hFFF9D;
  localparam logic [7:0] RETN_STAT_RST  = 8'h00;
  localparam logic [7:0] CLK_CTRL0_RST  = 8'h00;
  localparam logic [7:0] CLK_CTRL0_WMSK = 8'hAF;
  localparam int         RETN_FLAG_BIT  = 0;
  localparam int         RUN_BIT        = 7;
  localparam int         ONE_HZ_OE_BIT  = 5;
  localparam int         HOUR_FMT_BIT   = 3;
  localparam int         PERIOD_LSB     = 0;
  localparam logic [2:0] PER_OFF        = 3'h0;
  localparam logic [2:0] PER_HALF_SEC   = 3'h1;
  localparam logic [2:0] PER_SEC        = 3'h2;
  localparam logic [2:0] PER_MIN        = 3'h3;
  localparam logic [2:0] PER_HOUR       = 3'h4;
  localparam logic [2:0] PER_DAY        = 3'h5;
endpackage

/* File: logic/rtc_period_tick.sv */
// Constant-period event selector for the clock interrupt
`timescale 1ns/100ps
`default_nettype none
module rtc_period_tick
  import rtc_ctrl_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             run,
  input  wire logic [SEL_W-1:0] sel,
  input  wire logic             tick_half_sec,
  input  wire logic             tick_sec,
  input  wire logic             tick_min,
  input  wire logic             tick_hour,
  input  wire logic             tick_day,
  input  wire logic             tick_month,
  output logic                  evt
);
  logic evt_reg;
  logic evt_next;

  always_comb begin
    evt_next = 1'b0;
    if (run) begin
      case (sel)
        PER_OFF:      evt_next = 1'b0;
        PER_HALF_SEC: evt_next = tick_half_sec;
        PER_SEC:      evt_next = tick_sec;
        PER_MIN:      evt_next = tick_min;
        PER_HOUR:     evt_next = tick_hour;
        PER_DAY:      evt_next = tick_day;
        default:      evt_next = tick_month;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      evt_reg <= 1'b0;
    end else begin
      evt_reg <= evt_next;
    end
  end

  assign evt = evt_reg;
endmodule
`default_nettype wire

/* File: logic/rtc_ctrl.sv */
// Clock control register 0, retention status flag and 1 Hz pin gating
// Notes on behaviour
// - Writing 1 to retention flag bit sets it; writing 0 does nothing.
// - Retention status clears only on retention-voltage reset; other resets keep it.
// - Flag 1 means no retention reset; 0 means never set or reset happened.
// - Retention status takes byte writes only; control register takes bit and byte writes.
// - Control register clears to zero on retention-voltage reset.
// - Run bit 7 stops counter at 0, counts at 1.
// - 1 Hz pin toggles only when output enable bit 5 and run bit are set.
// - With run bit clear there is no 1 Hz output whatever the enable.
// - Changing output enable while running may glitch the pin; software avoids it.
// - Hour format bit 3 picks 12-hour at 0, 24-hour at 1.
// - Period field selects off, half second, second, minute, hour, day or month.
// - With peripheral clock gate low, control writes ignored; retention writes still work.
`timescale 1ns/100ps
`default_nettype none
module rtc_ctrl
  import rtc_ctrl_pkg::*;
(
  input  wire logic              CLK_SYS,
  input  wire logic              SRST,
  input  wire logic              RETN_RST,
  input  wire logic              PCLK_GATE,
  input  wire logic [ADDR_W-1:0] SFR_ADDR,
  input  wire logic              SFR_WR,
  input  wire logic              SFR_BIT_WR,
  input  wire logic [2:0]        SFR_BIT_SEL,
  input  wire logic [DATA_W-1:0] SFR_WDATA,
  input  wire logic              SFR_RD,
  output logic      [DATA_W-1:0] SFR_RDATA,
  input  wire logic              TICK_HALF_SEC,
  input  wire logic              TICK_SEC,
  input  wire logic              TICK_MIN,
  input  wire logic              TICK_HOUR,
  input  wire logic              TICK_DAY,
  input  wire logic              TICK_MONTH,
  input  wire logic              ONE_HZ_SRC,
  output logic                   COUNT_RUN,
  output logic                   HOUR_24,
  output logic      [SEL_W-1:0]  PERIOD_SEL,
  output logic                   ONE_HZ_OUT,
  output logic                   ONE_HZ_OE,
  output logic                   PERIOD_FLAG_SET,
  output logic                   CLOCK_IRQ,
  output logic                   RETN_FLAG
);
  logic [DATA_W-1:0] ctrl_reg;
  logic [DATA_W-1:0] ctrl_next;
  logic              retn_reg;
  logic              retn_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic              one_hz_reg;
  logic              one_hz_next;
  logic              one_hz_oe_reg;
  logic              one_hz_oe_next;
  logic              period_evt;
  logic              sel_ctrl;
  logic              sel_retn;
  logic [DATA_W-1:0] bit_mask;

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    addr_hit = (a == off);
  endfunction

  assign sel_ctrl = addr_hit(SFR_ADDR, CLK_CTRL0_OFF);
  assign sel_retn = addr_hit(SFR_ADDR, RETN_STAT_OFF);
  assign bit_mask = DATA_W'(1) << SFR_BIT_SEL;

  // Register writes
  always_comb begin
    ctrl_next = ctrl_reg;
    retn_next = retn_reg;
    if (RETN_RST) begin
      ctrl_next = CLK_CTRL0_RST;
      retn_next = RETN_STAT_RST[RETN_FLAG_BIT];
    end else begin
      if (PCLK_GATE && sel_ctrl) begin
        if (SFR_WR) begin
          ctrl_next = SFR_WDATA & CLK_CTRL0_WMSK;
        end else if (SFR_BIT_WR) begin
          if (SFR_WDATA[0]) begin
            ctrl_next = (ctrl_reg | bit_mask) & CLK_CTRL0_WMSK;
          end else begin
            ctrl_next = ctrl_reg & ~bit_mask;
          end
        end
      end
      if (sel_retn && SFR_WR && SFR_WDATA[RETN_FLAG_BIT]) begin
        retn_next = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    ctrl_reg <= ctrl_next;
    retn_reg <= retn_next;
  end

  // Read port and 1 Hz pin
  always_comb begin
    rdata_next = rdata_reg;
    if (SFR_RD) begin
      rdata_next = '0;
      if (sel_ctrl) begin
        rdata_next = ctrl_reg;
      end else if (sel_retn) begin
        rdata_next[RETN_FLAG_BIT] = retn_reg;
      end
    end
    // Registered gating keeps the pin clean except on an enable change
    one_hz_oe_next = ctrl_reg[RUN_BIT] && ctrl_reg[ONE_HZ_OE_BIT];
    one_hz_next    = one_hz_oe_next && ONE_HZ_SRC;
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST || RETN_RST) begin
      rdata_reg     <= '0;
      one_hz_reg    <= 1'b0;
      one_hz_oe_reg <= 1'b0;
    end else begin
      rdata_reg     <= rdata_next;
      one_hz_reg    <= one_hz_next;
      one_hz_oe_reg <= one_hz_oe_next;
    end
  end

  rtc_period_tick u_period (
    .clk           (CLK_SYS),
    .srst          (SRST || RETN_RST),
    .run           (ctrl_reg[RUN_BIT]),
    .sel           (ctrl_reg[PERIOD_LSB +: SEL_W]),
    .tick_half_sec (TICK_HALF_SEC),
    .tick_sec      (TICK_SEC),
    .tick_min      (TICK_MIN),
    .tick_hour     (TICK_HOUR),
    .tick_day      (TICK_DAY),
    .tick_month    (TICK_MONTH),
    .evt           (period_evt)
  );

  assign SFR_RDATA       = rdata_reg;
  assign COUNT_RUN       = ctrl_reg[RUN_BIT];
  assign HOUR_24         = ctrl_reg[HOUR_FMT_BIT];
  assign PERIOD_SEL      = ctrl_reg[PERIOD_LSB +: SEL_W];
  assign ONE_HZ_OUT      = one_hz_reg;
  assign ONE_HZ_OE       = one_hz_oe_reg;
  assign PERIOD_FLAG_SET = period_evt;
  assign CLOCK_IRQ       = period_evt;
  assign RETN_FLAG       = retn_reg;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SRST);

  a_retn_set_one: assert property ((SFR_WR && sel_retn && SFR_WDATA[0] && !RETN_RST) |=> RETN_FLAG)
    else $error("retention flag not set by write of one");
  a_retn_zero_ign: assert property ((SFR_WR && sel_retn && !SFR_WDATA[0] && !RETN_RST) |=> $stable(RETN_FLAG))
    else $error("retention flag changed by write of zero");
  a_retn_bit_ign: assert property ((SFR_BIT_WR && !SFR_WR && sel_retn && !RETN_RST) |=> $stable(RETN_FLAG))
    else $error("retention flag changed by bit write");
  a_retn_clear_rst: assert property (RETN_RST |=> (!RETN_FLAG && ctrl_reg == CLK_CTRL0_RST))
    else $error("retention reset did not clear registers");
  a_retn_keep_flag: assert property (disable iff (1'b0) (SRST && !RETN_RST && !SFR_WR) |=> $stable(RETN_FLAG))
    else $error("retention flag lost on system reset");
  a_gate_blocks_wr: assert property ((!PCLK_GATE && !RETN_RST) |=> $stable(ctrl_reg))
    else $error("control register written with gate off");
  a_bit_wr_run: assert property ((PCLK_GATE && sel_ctrl && SFR_BIT_WR && !SFR_WR && SFR_BIT_SEL == 3'(RUN_BIT)
                                  && !RETN_RST) |=> COUNT_RUN == $past(SFR_WDATA[0]))
    else $error("bit write to run bit not applied");
  a_hour_fmt_wr: assert property ((PCLK_GATE && sel_ctrl && SFR_WR && !RETN_RST)
                                  |=> HOUR_24 == $past(SFR_WDATA[HOUR_FMT_BIT]))
    else $error("hour format bit not written");
  a_rsvd_zero: assert property ((ctrl_reg & ~CLK_CTRL0_WMSK) == '0)
    else $error("reserved control bits not zero");
  a_one_hz_off: assert property ((!COUNT_RUN && !RETN_RST) |=> (!ONE_HZ_OE && !ONE_HZ_OUT))
    else $error("1 Hz output while counter stopped");
  a_one_hz_pass: assert property ((COUNT_RUN && ctrl_reg[ONE_HZ_OE_BIT] && !RETN_RST)
                                  |=> (ONE_HZ_OE && ONE_HZ_OUT == $past(ONE_HZ_SRC)))
    else $error("1 Hz output not following source");
  a_period_sec: assert property ((COUNT_RUN && PERIOD_SEL == PER_SEC && TICK_SEC && !RETN_RST)
                                 |=> (PERIOD_FLAG_SET && CLOCK_IRQ))
    else $error("second period event missing");
  a_period_off: assert property ((PERIOD_SEL == PER_OFF || !COUNT_RUN) |=> !CLOCK_IRQ)
    else $error("period event while disabled");

  c_retn_set: cover property (SFR_WR && sel_retn && SFR_WDATA[0] ##1 RETN_FLAG);
  c_one_hz_on: cover property (ONE_HZ_OE && ONE_HZ_OUT);
  c_month_evt: cover property (PERIOD_SEL[2:1] == 2'b11 && TICK_MONTH && COUNT_RUN ##1 CLOCK_IRQ);
  c_gate_blocked: cover property (!PCLK_GATE && sel_ctrl && SFR_WR);
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
// Testbench for clock control register, retention flag and 1 Hz gating
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import rtc_ctrl_pkg::*;
  logic              clk_sys = 1'b0, srst = 1'b1, retn_rst = 1'b1, pclk_gate = 1'b1;
  logic              sfr_wr = 1'b0, sfr_bit_wr = 1'b0, sfr_rd = 1'b0, src = 1'b0, src_d = 1'b0;
  logic [ADDR_W-1:0] sfr_addr = '0;
  logic [2:0]        bsel = 3'h0;
  logic [DATA_W-1:0] wdata = 8'h00;
  logic [DATA_W-1:0] rdata;
  logic [5:0]        tk = 6'h00;
  logic              run, h24, oe, ohz, pfs, irq, flag;
  logic [SEL_W-1:0]  psel;
  int                miscompares = 0;
  int                samples_checked = 0;

  rtc_ctrl rtc_ctrl_i (.CLK_SYS(clk_sys), .SRST(srst), .RETN_RST(retn_rst), .PCLK_GATE(pclk_gate),
    .SFR_ADDR(sfr_addr), .SFR_WR(sfr_wr), .SFR_BIT_WR(sfr_bit_wr), .SFR_BIT_SEL(bsel),
    .SFR_WDATA(wdata), .SFR_RD(sfr_rd), .SFR_RDATA(rdata), .TICK_HALF_SEC(tk[0]), .TICK_SEC(tk[1]),
    .TICK_MIN(tk[2]), .TICK_HOUR(tk[3]), .TICK_DAY(tk[4]), .TICK_MONTH(tk[5]), .ONE_HZ_SRC(src),
    .COUNT_RUN(run), .HOUR_24(h24), .PERIOD_SEL(psel), .ONE_HZ_OUT(ohz), .ONE_HZ_OE(oe),
    .PERIOD_FLAG_SET(pfs), .CLOCK_IRQ(irq), .RETN_FLAG(flag));

  initial forever #25 clk_sys = ~clk_sys;
  // Slow square wave standing in for the counter's 1 Hz level
  always begin
    repeat (4) @(posedge clk_sys);
    src <= ~src;
  end
  always @(posedge clk_sys) src_d <= src;

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    sfr_addr <= a; wdata <= d; sfr_wr <= 1'b1;
    @(posedge clk_sys);
    sfr_wr <= 1'b0;
    #1;
  endtask

  task automatic bw(input logic [19:0] a, input logic [2:0] b, input logic v);
    @(posedge clk_sys);
    sfr_addr <= a; bsel <= b; wdata <= {7'h00, v}; sfr_bit_wr <= 1'b1;
    @(posedge clk_sys);
    sfr_bit_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input string n, input logic [19:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    sfr_addr <= a; sfr_rd <= 1'b1;
    @(posedge clk_sys);
    sfr_rd <= 1'b0;
    #1 chk(n, e, rdata);
  endtask

  task automatic pulse_reset(input logic retention);
    @(posedge clk_sys);
    if (retention) retn_rst <= 1'b1; else srst <= 1'b1;
    @(posedge clk_sys);
    retn_rst <= 1'b0; srst <= 1'b0;
  endtask

  task automatic t_retention();
    rd("stat", RETN_STAT_OFF, 8'h00);
    chk("flag", 8'h00, {7'h00, flag});
    wr(RETN_STAT_OFF, 8'h00); rd("stat", RETN_STAT_OFF, 8'h00);
    bw(RETN_STAT_OFF, 3'h0, 1'b1); rd("stat", RETN_STAT_OFF, 8'h00);
    wr(RETN_STAT_OFF, 8'hFF); rd("stat", RETN_STAT_OFF, 8'h01);
    chk("flag", 8'h01, {7'h00, flag});
    wr(RETN_STAT_OFF, 8'h00); rd("stat", RETN_STAT_OFF, 8'h01);
    pulse_reset(1'b0); rd("stat", RETN_STAT_OFF, 8'h01);
    pulse_reset(1'b1); rd("stat", RETN_STAT_OFF, 8'h00);
  endtask

  task automatic t_control();
    wr(CLK_CTRL0_OFF, 8'hFF); rd("ctrl", CLK_CTRL0_OFF, 8'hAF);
    chk("fields", 8'h1F, {3'h0, run, h24, psel});
    bw(CLK_CTRL0_OFF, 3'h7, 1'b0); rd("ctrl", CLK_CTRL0_OFF, 8'h2F);
    bw(CLK_CTRL0_OFF, 3'h3, 1'b0); rd("ctrl", CLK_CTRL0_OFF, 8'h27);
    bw(CLK_CTRL0_OFF, 3'h6, 1'b1); rd("ctrl", CLK_CTRL0_OFF, 8'h27);
    pulse_reset(1'b0); rd("ctrl", CLK_CTRL0_OFF, 8'h27);
    pulse_reset(1'b1); rd("ctrl", CLK_CTRL0_OFF, 8'h00);
    rd("unmapped", 20'h00000, 8'h00);
    @(posedge clk_sys) pclk_gate <= 1'b0;
    wr(CLK_CTRL0_OFF, 8'h80); rd("ctrl", CLK_CTRL0_OFF, 8'h00);
    wr(RETN_STAT_OFF, 8'h01); rd("stat", RETN_STAT_OFF, 8'h01);
    @(posedge clk_sys) pclk_gate <= 1'b1;
  endtask

  task automatic t_one_hz();
    wr(CLK_CTRL0_OFF, 8'h20); repeat (2) @(posedge clk_sys);
    #1 chk("pin", 8'h00, {6'h00, oe, ohz});
    wr(CLK_CTRL0_OFF, 8'h80); repeat (2) @(posedge clk_sys);
    #1 chk("pin", 8'h00, {6'h00, oe, ohz});
    wr(CLK_CTRL0_OFF, 8'hA0);
    repeat (10) begin
      @(posedge clk_sys);
      #1 chk("pin", {6'h00, 1'b1, src_d}, {6'h00, oe, ohz});
    end
    wr(CLK_CTRL0_OFF, 8'h20); @(posedge clk_sys);
    #1 chk("pin", 8'h00, {6'h00, oe, ohz});
  endtask

  task automatic t_period();
    logic hit;
    for (int s = 0; s < 8; s++) begin
      // Field is only changed with the counter stopped
      wr(CLK_CTRL0_OFF, 8'(s));
      wr(CLK_CTRL0_OFF, 8'h80 | 8'(s));
      for (int k = 0; k < 6; k++) begin
        hit = (s != 0) && (k == ((s >= 6) ? 5 : s - 1));
        @(posedge clk_sys) tk <= 6'h01 << k;
        @(posedge clk_sys) tk <= 6'h00;
        #1 chk("event", {6'h00, hit, hit}, {6'h00, pfs, irq});
      end
    end
    wr(CLK_CTRL0_OFF, 8'h02);
    @(posedge clk_sys) tk <= 6'h02;
    @(posedge clk_sys) tk <= 6'h00;
    #1 chk("event", 8'h00, {6'h00, pfs, irq});
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0; retn_rst <= 1'b0;
    t_retention();
    t_control();
    t_one_hz();
    t_period();
    report_and_stop();
  end

  initial begin
    repeat (5000) @(posedge clk_sys);
    miscompares++;
    report_and_stop();
  end
endmodule
`default_nettype wire
